/* asti_map.svh */
// Register offsets, field positions and timing counts for the async timer bridge
`ifndef ASTI_MAP_SVH
`define ASTI_MAP_SVH
`define ASTI_OFF_CTL 8'h00
`define ASTI_OFF_CNT 8'h04
`define ASTI_OFF_CMP 8'h08
`define ASTI_OFF_STAT 8'h0C
`define ASTI_OFF_MASK 8'h10
`define ASTI_OFF_FLAG 8'h14
`define ASTI_RST_BYTE 8'h00
`define ASTI_CNT_MAX 8'hFF
`define ASTI_CNT_ZERO 8'h00
`define ASTI_CH_CTL 0
`define ASTI_CH_CMP 1
`define ASTI_CH_CNT 2
`define ASTI_BIT_OVF 0
`define ASTI_BIT_CMP 1
`define ASTI_BIT_SEL 3
`define ASTI_CTL_CS_LO 0
`define ASTI_CTL_CS_HI 2
`define ASTI_CTL_PWM 6
`define ASTI_CTL_COM_LO 4
`define ASTI_CTL_COM_HI 5
`define ASTI_COM_TOGGLE 2'h1
`define ASTI_COM_CLEAR 2'h2
`define ASTI_COM_SET 2'h3
`define ASTI_COMMIT_EDGES 2'h2
`define ASTI_FLAG_DELAY 3
`define ASTI_STALL_CYCLES 3'h4
`endif

/* asti_pkg.sv */
// Types shared by the async timer bridge
package asti_pkg;
  // Wake sequencer states, Gray coded along idle-armed-waking-stall
  typedef enum logic [1:0] {
    ASTI_IDLE = 2'h0,
    ASTI_ARMED = 2'h1,
    ASTI_WAKING = 2'h3,
    ASTI_STALL = 2'h2
  } asti_wake_e;
  typedef logic [7:0] asti_byte_t;
  typedef logic [2:0] asti_chan_t;
endpackage

/* asti_sync2.sv */
// Two-flop synchroniser for levels entering the clk_i domain
`timescale 1ns/10ps
module asti_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg; // First stage, read only by the second
  // Both stages reset to zero; only q_o is used downstream
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // asti_sync2

/* asti_timer_bridge.sv */
// Async timer bridge: holding registers, busy flags, counter copy, flags and wake
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "asti_map.svh"
module asti_timer_bridge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic osc_clock_pin_i,
  input wire logic osc_stop_i,
  input wire logic sleep_i,
  input wire logic cpu_irq_enable_i,
  input wire logic cmp_vec_ack_i,
  input wire logic ovf_vec_ack_i,
  output logic cmp_irq_o,
  output logic ovf_irq_o,
  output logic cmp_out_o,
  output logic wake_o,
  output logic cpu_stall_o,
  output asti_pkg::asti_chan_t update_pending_o
);
  import asti_pkg::*;

  // Oscillator pin brought into clk_i domain
  logic osc_sync;
  logic osc_prev_reg; // Previous synchronised level, for edge detect
  logic osc_edge; // One-cycle pulse on each rising oscillator edge

  // Register file
  asti_byte_t timer_control_reg; // Committed control value
  asti_byte_t compare_value_reg; // Committed compare value
  asti_byte_t counter_value_reg; // Live counter
  asti_byte_t count_copy_reg; // Counter copy read by software
  asti_byte_t irq_mask_reg;
  asti_byte_t irq_flag_reg;
  logic async_clock_select_reg; // 1 = oscillator clock

  // Per-channel transfer state
  asti_byte_t hold_reg [3]; // Holding registers
  asti_chan_t pend_reg; // Raw pending flags
  logic [1:0] edge_cnt_reg [3]; // Oscillator edges seen while pending
  asti_chan_t commit_reg; // One-cycle commit pulses
  asti_chan_t pend_sync; // Pending flags after synchroniser
  logic ctl_update_pending;
  logic cmp_update_pending;
  logic count_update_pending;

  // Timer events
  logic tick; // Timer clock enable
  logic running; // Clock-select bits nonzero
  logic count_down_reg; // Phase-correct direction
  logic cmp_hit; // Compare match on this tick
  logic ovf_hit; // Overflow on this tick
  logic [`ASTI_FLAG_DELAY-1:0] cmp_pipe_reg; // Flag delay line
  logic [`ASTI_FLAG_DELAY-1:0] ovf_pipe_reg;
  logic cmp_set;
  logic ovf_set;

  // Bus decode
  logic acc; // Access phase
  logic wr_en; // Write completes this edge
  logic rd_en; // Read completes this edge
  logic mapped;
  asti_chan_t wr_chan; // Which holding register is written
  asti_byte_t wbyte;
  asti_byte_t rd_mux;

  // Wake sequencer
  asti_wake_e wake_state_reg;
  logic [2:0] stall_cnt_reg;
  logic irq_ready_reg; // Interrupt logic rearmed
  logic wake_cond;

  // Oscillator pin is asynchronous: two flops before any logic looks at it
  asti_sync2 #(.WIDTH(1)) u_osc_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(osc_clock_pin_i),
    .q_o(osc_sync)
  );

  // Edge detect on the synchronised oscillator level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_sync;
    end
  end
  // Stopped oscillator gives no edges at all
  assign osc_edge = osc_sync & ~osc_prev_reg & ~osc_stop_i;

  // Timer clock: every I/O cycle, or the oscillator edge when selected
  assign tick = async_clock_select_reg ? osc_edge : 1'b1;
  assign running = |timer_control_reg[`ASTI_CTL_CS_HI:`ASTI_CTL_CS_LO];

  // APB decode; pready rises one cycle into the access phase
  assign acc = psel_i & penable_i;
  assign wr_en = acc & pwrite_i & pready_o;
  assign rd_en = acc & ~pwrite_i & pready_o;
  assign wbyte = pwdata_i[7:0];
  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      `ASTI_OFF_CTL, `ASTI_OFF_CNT, `ASTI_OFF_CMP, `ASTI_OFF_STAT, `ASTI_OFF_MASK, `ASTI_OFF_FLAG: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end
  assign wr_chan[`ASTI_CH_CTL] = wr_en & (paddr_i == `ASTI_OFF_CTL);
  assign wr_chan[`ASTI_CH_CMP] = wr_en & (paddr_i == `ASTI_OFF_CMP);
  assign wr_chan[`ASTI_CH_CNT] = wr_en & (paddr_i == `ASTI_OFF_CNT);

  // Bus handshake: one wait state, error on unmapped address
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
    end
  end

  // One holding register per destination, so transfers never disturb each other
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          hold_reg[g] <= `ASTI_RST_BYTE;
          pend_reg[g] <= 1'b0;
          edge_cnt_reg[g] <= 2'h0;
          commit_reg[g] <= 1'b0;
        end else begin
          commit_reg[g] <= 1'b0;
          if (wr_chan[g]) begin
            // A write lands in the holding register first
            hold_reg[g] <= wbyte;
            if (async_clock_select_reg) begin
              // Async mode: busy until two oscillator edges have passed
              pend_reg[g] <= 1'b1;
              edge_cnt_reg[g] <= 2'h0;
            end else begin
              // Sync mode commits on the next cycle with no busy flag
              commit_reg[g] <= 1'b1;
            end
          end else if (pend_reg[g] && osc_edge) begin
            if (edge_cnt_reg[g] + 2'h1 == `ASTI_COMMIT_EDGES) begin
              // Second rising edge: latch into destination
              commit_reg[g] <= 1'b1;
              pend_reg[g] <= 1'b0;
              edge_cnt_reg[g] <= 2'h0;
            end else begin
              edge_cnt_reg[g] <= edge_cnt_reg[g] + 2'h1;
            end
          end
        end
      end
    end
  endgenerate

  // Busy flags reach software through a two-flop synchroniser, as a real
  // timer-domain flag would; this adds two cycles of status lag
  asti_sync2 #(.WIDTH(3)) u_pend_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pend_reg),
    .q_o(pend_sync)
  );
  assign ctl_update_pending = pend_sync[`ASTI_CH_CTL];
  assign cmp_update_pending = pend_sync[`ASTI_CH_CMP];
  assign count_update_pending = pend_sync[`ASTI_CH_CNT];

  // Control and compare destinations load on commit only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_control_reg <= `ASTI_RST_BYTE;
      compare_value_reg <= `ASTI_RST_BYTE;
    end else begin
      if (commit_reg[`ASTI_CH_CTL]) begin
        timer_control_reg <= hold_reg[`ASTI_CH_CTL];
      end
      if (commit_reg[`ASTI_CH_CMP]) begin
        compare_value_reg <= hold_reg[`ASTI_CH_CMP];
      end
    end
  end

  // Clock-select bit; switching may corrupt in-flight transfers, software's problem
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      async_clock_select_reg <= 1'b0;
    end else if (wr_en && paddr_i == `ASTI_OFF_STAT) begin
      async_clock_select_reg <= wbyte[`ASTI_BIT_SEL];
    end
  end

  // Counter: commit wins over counting; phase-correct mode counts up and down
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_value_reg <= `ASTI_CNT_ZERO;
      count_down_reg <= 1'b0;
    end else if (commit_reg[`ASTI_CH_CNT]) begin
      counter_value_reg <= hold_reg[`ASTI_CH_CNT];
    end else if (tick && running) begin
      if (!timer_control_reg[`ASTI_CTL_PWM]) begin
        counter_value_reg <= counter_value_reg + 8'h01;
        count_down_reg <= 1'b0;
      end else if (count_down_reg) begin
        // Reverse at zero
        if (counter_value_reg == `ASTI_CNT_ZERO) begin
          count_down_reg <= 1'b0;
          counter_value_reg <= counter_value_reg + 8'h01;
        end else begin
          counter_value_reg <= counter_value_reg - 8'h01;
        end
      end else if (counter_value_reg == `ASTI_CNT_MAX) begin
        count_down_reg <= 1'b1;
        counter_value_reg <= counter_value_reg - 8'h01;
      end else begin
        counter_value_reg <= counter_value_reg + 8'h01;
      end
    end
  end

  // Timer events; compare is blanked while a counter or compare write is in flight
  assign cmp_hit = tick & running & (counter_value_reg == compare_value_reg)
                   & ~pend_reg[`ASTI_CH_CMP] & ~pend_reg[`ASTI_CH_CNT];
  assign ovf_hit = tick & running & (timer_control_reg[`ASTI_CTL_PWM]
                   ? (count_down_reg & (counter_value_reg == `ASTI_CNT_ZERO))
                   : (counter_value_reg == `ASTI_CNT_MAX));

  // Counter copy follows every I/O cycle in sync mode and each oscillator edge in async mode, frozen there while I/O clock sleeps,
  // so a read just after wake still shows the pre-sleep value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_copy_reg <= `ASTI_CNT_ZERO;
    end else if (!async_clock_select_reg) begin
      count_copy_reg <= counter_value_reg;
    end else if (osc_edge && !sleep_i) begin
      count_copy_reg <= counter_value_reg;
    end
  end

  // Compare pin driven straight from the timer tick, no bus-side sync
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_out_o <= 1'b0;
    end else if (cmp_hit) begin
      case (timer_control_reg[`ASTI_CTL_COM_HI:`ASTI_CTL_COM_LO])
        `ASTI_COM_TOGGLE: begin
          cmp_out_o <= ~cmp_out_o;
        end
        `ASTI_COM_CLEAR: begin
          cmp_out_o <= 1'b0;
        end
        `ASTI_COM_SET: begin
          cmp_out_o <= 1'b1;
        end
        default: begin
          cmp_out_o <= cmp_out_o;
        end
      endcase
    end
  end

  // Async events cross with three I/O cycles of delay before the flag shows
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_pipe_reg <= '0;
      ovf_pipe_reg <= '0;
    end else begin
      cmp_pipe_reg <= {cmp_pipe_reg[`ASTI_FLAG_DELAY-2:0], cmp_hit & async_clock_select_reg};
      ovf_pipe_reg <= {ovf_pipe_reg[`ASTI_FLAG_DELAY-2:0], ovf_hit & async_clock_select_reg};
    end
  end
  assign cmp_set = async_clock_select_reg ? cmp_pipe_reg[`ASTI_FLAG_DELAY-1] : cmp_hit;
  assign ovf_set = async_clock_select_reg ? ovf_pipe_reg[`ASTI_FLAG_DELAY-1] : ovf_hit;

  // Flags: set beats clear; cleared by vector or by writing one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_flag_reg <= `ASTI_RST_BYTE;
    end else begin
      if (cmp_set) begin
        irq_flag_reg[`ASTI_BIT_CMP] <= 1'b1;
      end else if (cmp_vec_ack_i || (wr_en && paddr_i == `ASTI_OFF_FLAG && wbyte[`ASTI_BIT_CMP])) begin
        irq_flag_reg[`ASTI_BIT_CMP] <= 1'b0;
      end
      if (ovf_set) begin
        irq_flag_reg[`ASTI_BIT_OVF] <= 1'b1;
      end else if (ovf_vec_ack_i || (wr_en && paddr_i == `ASTI_OFF_FLAG && wbyte[`ASTI_BIT_OVF])) begin
        irq_flag_reg[`ASTI_BIT_OVF] <= 1'b0;
      end
    end
  end

  // Mask register, plain read/write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_reg <= `ASTI_RST_BYTE;
    end else if (wr_en && paddr_i == `ASTI_OFF_MASK) begin
      irq_mask_reg <= wbyte;
    end
  end

  // Interrupt requests need global enable, mask bit and flag together
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_irq_o <= 1'b0;
      ovf_irq_o <= 1'b0;
    end else begin
      cmp_irq_o <= cpu_irq_enable_i & irq_mask_reg[`ASTI_BIT_CMP] & irq_flag_reg[`ASTI_BIT_CMP];
      ovf_irq_o <= cpu_irq_enable_i & irq_mask_reg[`ASTI_BIT_OVF] & irq_flag_reg[`ASTI_BIT_OVF];
    end
  end

  // Wake condition from an enabled, raised event while asleep
  assign wake_cond = sleep_i & irq_ready_reg & cpu_irq_enable_i
                     & |(irq_mask_reg[`ASTI_BIT_CMP:`ASTI_BIT_OVF] & irq_flag_reg[`ASTI_BIT_CMP:`ASTI_BIT_OVF]);

  // Wake sequencer: wait one timer tick, then stall the processor four cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_state_reg <= ASTI_IDLE;
      stall_cnt_reg <= 3'h0;
      wake_o <= 1'b0;
      cpu_stall_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      case (wake_state_reg)
        ASTI_IDLE: begin
          cpu_stall_o <= 1'b0;
          if (wake_cond) begin
            wake_state_reg <= ASTI_ARMED;
          end
        end
        ASTI_ARMED: begin
          if (tick) begin
            wake_state_reg <= ASTI_WAKING;
          end
        end
        ASTI_WAKING: begin
          wake_o <= 1'b1;
          cpu_stall_o <= 1'b1;
          stall_cnt_reg <= `ASTI_STALL_CYCLES - 3'h1;
          wake_state_reg <= ASTI_STALL;
        end
        ASTI_STALL: begin
          if (stall_cnt_reg == 3'h0) begin
            cpu_stall_o <= 1'b0;
            wake_state_reg <= ASTI_IDLE;
          end else begin
            stall_cnt_reg <= stall_cnt_reg - 3'h1;
          end
        end
        default: begin
          wake_state_reg <= ASTI_IDLE;
        end
      endcase
    end
  end

  // Wake condition needs one timer tick after a wake before it can fire again; irq outputs are not gated
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_ready_reg <= 1'b1;
    end else if (wake_state_reg == ASTI_WAKING) begin
      irq_ready_reg <= 1'b0;
    end else if (tick) begin
      irq_ready_reg <= 1'b1;
    end
  end

  // Read mux: counter from its copy, control/compare from holding registers
  always_comb begin
    rd_mux = `ASTI_RST_BYTE;
    case (paddr_i)
      `ASTI_OFF_CTL: begin
        rd_mux = hold_reg[`ASTI_CH_CTL];
      end
      `ASTI_OFF_CMP: begin
        rd_mux = hold_reg[`ASTI_CH_CMP];
      end
      `ASTI_OFF_CNT: begin
        rd_mux = count_copy_reg;
      end
      `ASTI_OFF_STAT: begin
        rd_mux = {4'h0, async_clock_select_reg, count_update_pending, cmp_update_pending, ctl_update_pending};
      end
      `ASTI_OFF_MASK: begin
        rd_mux = irq_mask_reg;
      end
      `ASTI_OFF_FLAG: begin
        rd_mux = irq_flag_reg;
      end
      default: begin
        rd_mux = `ASTI_RST_BYTE;
      end
    endcase
  end

  // Read data registered in the cycle pready rises; held otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (acc && !pwrite_i && !pready_o) begin
      prdata_o <= {24'h00_0000, rd_mux};
    end
  end

  // Pending flags mirrored to a pin for wake-safe sleep entry
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      update_pending_o <= 3'h0;
    end else begin
      update_pending_o <= pend_sync;
    end
  end

endmodule // asti_timer_bridge

/* asti_osc_model.sv */
// Behavioural watch-crystal oscillator feeding the timer bridge pin
`timescale 1ns/10ps
module asti_osc_model (
  input wire logic stop_i,
  output logic osc_o
);
  // Free running at one tenth of clk_i, phase offset so edges never line up with clk_i
  initial begin
    osc_o = 1'b0;
    #13;
    forever begin
      #50;
      // Power-down and standby hold the pin still, so no timer edges reach the bridge
      if (!stop_i) begin
        osc_o = ~osc_o;
      end
    end
  end
endmodule // asti_osc_model

/* asti_timer_bridge_chk.sv */
// Port-level assertions for the async timer bridge
`timescale 1ns/10ps
`include "asti_map.svh"
module asti_timer_bridge_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sleep_i,
  input wire logic cpu_irq_enable_i,
  input wire logic cmp_irq_o,
  input wire logic ovf_irq_o,
  input wire logic wake_o,
  input wire logic cpu_stall_o
);
  // One clock domain, so one clocking and one reset serve every check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready stayed high past one cycle");
  chk_ready_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("pready not given after exactly one wait state");
  chk_err_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("pslverr outside a completing access");
  chk_err_unmapped: assert property (pready_o && paddr_i > `ASTI_OFF_FLAG |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  chk_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_cmp_gate: assert property (!cpu_irq_enable_i |=> !cmp_irq_o)
    else $error("compare irq without global enable");
  chk_ovf_gate: assert property (!cpu_irq_enable_i |=> !ovf_irq_o)
    else $error("overflow irq without global enable");
  chk_stall_four: assert property ($rose(wake_o) |-> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("stall not four cycles after wake");
  chk_wake_sleep: assert property (wake_o |-> $past(sleep_i) ##1 !wake_o)
    else $error("wake pulse without sleep or too long");
endmodule // asti_timer_bridge_chk
bind asti_timer_bridge asti_timer_bridge_chk asti_timer_bridge_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .sleep_i(sleep_i), .cpu_irq_enable_i(cpu_irq_enable_i), .cmp_irq_o(cmp_irq_o),
  .ovf_irq_o(ovf_irq_o), .wake_o(wake_o), .cpu_stall_o(cpu_stall_o));

/* asti_timer_bridge_tb.sv */
// Self-checking testbench for the async timer bridge
`timescale 1ns/10ps
`include "asti_map.svh"
module asti_timer_bridge_tb;
  import asti_pkg::*;
  logic clk_i = 1'b0; // 100 MHz core clock
  logic rst_i = 1'b1; // Async reset, high
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic osc, osc_stop = 1'b0, sleep = 1'b0, cpu_ie = 1'b0, cack = 1'b0, oack = 1'b0;
  logic [31:0] prdata, rd, c1; // Read data and captured values
  logic pready, perr, er, cmp_irq, ovf_irq, cmp_out, wake, stall;
  asti_chan_t pend; // Synchronised busy flags
  int bad_count = 0;
  int checks = 0;
  int n;
  asti_osc_model asti_osc_model_i (.stop_i(osc_stop), .osc_o(osc));
  asti_timer_bridge asti_timer_bridge_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .osc_clock_pin_i(osc), .osc_stop_i(osc_stop), .sleep_i(sleep),
    .cpu_irq_enable_i(cpu_ie), .cmp_vec_ack_i(cack), .ovf_vec_ack_i(oack), .cmp_irq_o(cmp_irq),
    .ovf_irq_o(ovf_irq), .cmp_out_o(cmp_out), .wake_o(wake), .cpu_stall_o(stall), .update_pending_o(pend));
  // Core clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; pready and read data are taken at the rising edge that completes it,
  // and the request is released only after that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read until every bit of m is set, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    n = 0;
    apb(1'b0, a, 32'h0);
    while ((rd & m) !== m && n < 1000) begin
      apb(1'b0, a, 32'h0);
      n++;
    end
  endtask
  // Wait for all busy flags to drop, counting cycles
  task automatic wait_idle;
    n = 0;
    @(negedge clk_i);
    while (pend !== 3'h0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs roughly 5500 cycles, so allow about nine times that
  initial begin
    #500000;
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, `ASTI_OFF_MASK, 32'h0); check(rd, 32'h0);
    apb(1'b0, `ASTI_OFF_FLAG, 32'h0); check(rd, 32'h0);
    apb(1'b0, `ASTI_OFF_STAT, 32'h0); check(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0); check({rd[30:0], er}, 32'h1);
    apb(1'b1, `ASTI_OFF_MASK, 32'h3); apb(1'b0, `ASTI_OFF_MASK, 32'h0); check(rd, 32'h3);
    // Synchronous clocking never shows busy
    apb(1'b1, `ASTI_OFF_CTL, 32'h0); repeat (3) @(negedge clk_i); check({29'h0, pend}, 32'h0);
    // Clock switch in the safe order, with no write while its busy flag is up
    apb(1'b1, `ASTI_OFF_MASK, 32'h0); apb(1'b1, `ASTI_OFF_STAT, 32'h8);
    apb(1'b1, `ASTI_OFF_CMP, 32'h5); apb(1'b1, `ASTI_OFF_CNT, 32'h0);
    repeat (4) @(negedge clk_i); check({29'h0, pend}, 32'h6);
    wait_idle(); check({31'h0, n > 3 && n < 40}, 32'h1);
    apb(1'b1, `ASTI_OFF_CTL, 32'h11); apb(1'b0, `ASTI_OFF_STAT, 32'h0); check(rd, 32'h9);
    apb(1'b0, `ASTI_OFF_CTL, 32'h0); check(rd, 32'h11);
    wait_idle(); check({31'h0, n > 3 && n < 40}, 32'h1);
    apb(1'b1, `ASTI_OFF_FLAG, 32'h3); apb(1'b1, `ASTI_OFF_MASK, 32'h3); cpu_ie <= 1'b1;
    // Compare match, then overflow, with irq gating
    poll(`ASTI_OFF_FLAG, 32'h2); check(rd, 32'h2);
    @(negedge clk_i); check({30'h0, cmp_irq, ovf_irq}, 32'h2);
    check({31'h0, cmp_out}, 32'h1);
    apb(1'b0, `ASTI_OFF_CNT, 32'h0); c1 = rd; repeat (30) @(posedge clk_i);
    apb(1'b0, `ASTI_OFF_CNT, 32'h0); check({31'h0, rd != c1}, 32'h1);
    poll(`ASTI_OFF_FLAG, 32'h3); check(rd, 32'h3);
    @(negedge clk_i); check({31'h0, ovf_irq}, 32'h1);
    @(posedge clk_i); cpu_ie <= 1'b0;
    repeat (2) @(negedge clk_i); check({30'h0, cmp_irq, ovf_irq}, 32'h0);
    @(posedge clk_i); cpu_ie <= 1'b1;
    apb(1'b1, `ASTI_OFF_FLAG, 32'h2); apb(1'b0, `ASTI_OFF_FLAG, 32'h0); check(rd, 32'h1);
    @(posedge clk_i); oack <= 1'b1;
    @(posedge clk_i); oack <= 1'b0;
    apb(1'b0, `ASTI_OFF_FLAG, 32'h0); check(rd, 32'h0);
    // Sleep with overflow as the only wake source
    apb(1'b1, `ASTI_OFF_MASK, 32'h1); wait_idle(); sleep <= 1'b1;
    n = 0;
    @(negedge clk_i);
    while (wake !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    check({31'h0, wake}, 32'h1);
    @(posedge clk_i); sleep <= 1'b0; oack <= 1'b1;
    @(posedge clk_i); oack <= 1'b0;
    apb(1'b1, `ASTI_OFF_CTL, 32'h11); wait_idle();
    apb(1'b0, `ASTI_OFF_CNT, 32'h0); check({31'h0, rd != 32'h0}, 32'h1);
    // Stopped oscillator never commits a write
    @(posedge clk_i); osc_stop <= 1'b1;
    apb(1'b1, `ASTI_OFF_CTL, 32'h11); repeat (60) @(negedge clk_i); check({29'h0, pend}, 32'h1);
    @(posedge clk_i); osc_stop <= 1'b0;
    wait_idle(); check({29'h0, pend}, 32'h0);
    // Back to synchronous clocking
    apb(1'b1, `ASTI_OFF_STAT, 32'h0); apb(1'b1, `ASTI_OFF_CTL, 32'h1);
    repeat (3) @(negedge clk_i); check({29'h0, pend}, 32'h0);
    report_and_stop();
  end
endmodule // asti_timer_bridge_tb
